// >>> src/sgsc_core.sv
// Purpose: Serial control core of a two-channel volume control
// Assumes: Shift clock well below SYS_CLK_IN/8; all pins asynchronous
// Notes:   Gain code drives the tap select; dB value = 31.5 - 0.5*(255-N)
//          Chain output lags its input by sixteen shift clocks per device
//          Zero-cross enable is taken when a word loads, not while it waits
//
// What this block does
// - Separate 8-bit unsigned gain code held for left and right
// - Gain code zero puts that channel in software mute
// - Codes 1..255 give 31.5 - 0.5*(255-N) dB in half-dB steps
// - Serial output carries bits shifted out of the 16-bit register
// - Zero-cross enable low disables zero-cross gain changes, high enables
// - Zero-cross handling is per channel, started only by a gain change
// - With zero-cross on, apply on positive crossing or after 16 ms
// - Hardware mute disconnects both outputs and grounds them
// - Hardware mute takes effect on next crossing or after 16 ms
// - Hardware mute assertion also starts offset calibration
// - Power-up holds about 100 ms reset in hardware mute
// - Calibration starts by itself when power-up reset ends
// - After calibration both gains load zero until host writes
// - Brown-out enters hardware mute; recovery reruns power-up sequence
// - Serial data accepted only while select is low
// - One transfer is 16 bits: right gain byte and left gain byte
// - Bytes MSB first, serial input sampled on rising shift clock
// - Serial output is high impedance while select is high
// - Right byte comes first, then left byte
// - Serial output changes on falling shift clock edge
`timescale 1ns/1ps
module sgsc_core
   import sgsc_pkg::*;
#(
   parameter logic [TMR_BITS-1:0] ZC_TIMEOUT = TMR_BITS'(ZC_TIMEOUT_CYC),
   parameter logic [TMR_BITS-1:0] POR_TIME   = TMR_BITS'(POR_CYC),
   parameter logic [TMR_BITS-1:0] CAL_TIME   = TMR_BITS'(CAL_CYC)
) (
   // Clock and reset
   input  wire logic                 SYS_CLK_IN,
   input  wire logic                 ARST_N_IN,
   // Serial control port
   input  wire logic                 SEL_N_IN,
   input  wire logic                 SHIFT_CLK_IN,
   input  wire logic                 SERIAL_IN_IN,
   output logic                      SERIAL_OUT_OUT,
   output logic                      SERIAL_OUT_OE_N_OUT,
   // Control pins and analog status
   input  wire logic                 ZERO_CROSS_ENABLE_IN,
   input  wire logic                 HW_MUTE_N_IN,
   input  wire logic                 BROWN_OUT_IN,
   input  wire logic                 ZC_LEFT_IN,
   input  wire logic                 ZC_RIGHT_IN,
   input  wire logic                 CAL_DONE_IN,
   // Analog control outputs
   output logic [GAIN_BITS-1:0]      GAIN_LEFT_OUT,
   output logic [GAIN_BITS-1:0]      GAIN_RIGHT_OUT,
   output logic                      SOFT_MUTE_LEFT_OUT,
   output logic                      SOFT_MUTE_RIGHT_OUT,
   output logic                      HW_MUTE_OUT,
   output logic                      CAL_START_OUT,
   output logic                      READY_OUT
);
   // Synchronisers: first stage read only by second stage
   // Reset values match idle pin levels, so no false edge follows reset
   logic [7:0] s1_q;
   logic [7:0] s2_q;
   logic [7:0] raw;
   assign raw = {CAL_DONE_IN, ZC_RIGHT_IN, ZC_LEFT_IN, BROWN_OUT_IN,
                 HW_MUTE_N_IN, SERIAL_IN_IN, SHIFT_CLK_IN, SEL_N_IN};

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_sync
         always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
            if (!ARST_N_IN) begin
               s1_q[gi] <= (gi == 0 || gi == 3) ? 1'b1 : 1'b0;
               s2_q[gi] <= (gi == 0 || gi == 3) ? 1'b1 : 1'b0;
            end else begin
               s1_q[gi] <= raw[gi];
               s2_q[gi] <= s1_q[gi];
            end
         end
      end
   endgenerate

   logic sel_n;
   logic sclk;
   logic serial_in;
   logic mute_n;
   logic bo;
   logic zcl;
   logic zcr;
   logic cal_done;
   assign {cal_done, zcr, zcl, bo, mute_n, serial_in, sclk, sel_n} = s2_q;

   // Edge history for shift clock, select and crossing inputs
   // Edges show in the same cycle as the synchronised level, two clocks after the pin
   logic sclk_q, sel_n_q, zcl_q, zcr_q, mute_n_q;
   always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         sclk_q   <= 1'b0;
         sel_n_q  <= 1'b1;
         zcl_q    <= 1'b0;
         zcr_q    <= 1'b0;
         mute_n_q <= 1'b1;
      end else begin
         sclk_q   <= sclk;
         sel_n_q  <= sel_n;
         zcl_q    <= zcl;
         zcr_q    <= zcr;
         mute_n_q <= mute_n;
      end
   end

   logic sclk_rise, sclk_fall, sel_rise, zcl_pos, zcr_pos, any_zc, mute_fall;
   assign sclk_rise = sclk & ~sclk_q;
   assign sclk_fall = ~sclk & sclk_q;
   assign sel_rise  = sel_n & ~sel_n_q;
   assign zcl_pos   = zcl & ~zcl_q;       // Comparator low to high = positive slope
   assign zcr_pos   = zcr & ~zcr_q;
   assign any_zc    = zcl_pos | zcr_pos;
   assign mute_fall = ~mute_n & mute_n_q;

   // Power sequencer: reset hold, calibration, then run
   sgsc_pwr_t     pwr_q;
   logic [TMR_BITS-1:0] pwr_tmr_q;
   logic          clear_gains;
   logic          running;
   assign running = (pwr_q == SGSC_PWR_RUN);
   // Brown-out outranks every state, so any dip restarts the whole sequence

   always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         pwr_q     <= SGSC_PWR_RESET;
         pwr_tmr_q <= '0;
      end else if (bo) begin
         pwr_q     <= SGSC_PWR_RESET;
         pwr_tmr_q <= '0;
      end else begin
         case (pwr_q)
            SGSC_PWR_RESET: begin
               if (pwr_tmr_q >= POR_TIME - 1) begin
                  pwr_q     <= SGSC_PWR_CAL;
                  pwr_tmr_q <= '0;
               end else begin
                  pwr_tmr_q <= pwr_tmr_q + 1'b1;
               end
            end
            SGSC_PWR_CAL: begin
               if (cal_done || pwr_tmr_q >= CAL_TIME - 1) begin
                  pwr_q     <= SGSC_PWR_RUN;
                  pwr_tmr_q <= '0;
               end else begin
                  pwr_tmr_q <= pwr_tmr_q + 1'b1;
               end
            end
            SGSC_PWR_RUN: pwr_q <= SGSC_PWR_RUN;
            default: pwr_q <= SGSC_PWR_RESET;
         endcase
      end
   end
   // Gains forced to zero while not running, so they are zero after calibration
   // Brown-out clears at once, so the codes fall together with ready
   assign clear_gains = !running || bo;

   // Calibration request: power-up, or each hardware mute assertion
   // Mute pulse starts the analog offset re-null as the pin falls, before the hardware mute output asserts
   always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         CAL_START_OUT <= 1'b0;
      end else begin
         CAL_START_OUT <= (pwr_q == SGSC_PWR_CAL) ||
                          (running && mute_fall);
      end
   end

   // Input shift register; chain output is its top bit
   // Cleared until ready, so words sent during power-up are lost
   logic [WORD_BITS-1:0] shreg_q;
   always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         shreg_q <= SHIFT_RESET;
      end else if (!running) begin
         shreg_q <= SHIFT_RESET;
      end else if (!sel_n && sclk_rise) begin
         shreg_q <= {shreg_q[WORD_BITS-2:0], serial_in};
      end
   end

   // Chain output updates on falling shift clock; high-Z while deselected
   // Cleared with the rest, so a rerun power-up starts the chain at zero
   always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         SERIAL_OUT_OUT      <= 1'b0;
         SERIAL_OUT_OE_N_OUT <= 1'b1;
      end else begin
         SERIAL_OUT_OE_N_OUT <= sel_n;
         if (!running) begin
            SERIAL_OUT_OUT <= 1'b0;
         end else if (!sel_n && sclk_fall) begin
            SERIAL_OUT_OUT <= shreg_q[WORD_BITS-1];
         end
      end
   end

   // Word load on select rising: right byte first in, then left
   // A short frame loads whatever partial word the register holds
   logic load;
   assign load = running && sel_rise;
   logic [GAIN_BITS-1:0] code_r, code_l;
   assign code_r = shreg_q[RIGHT_MSB:RIGHT_LSB];
   assign code_l = shreg_q[LEFT_MSB:LEFT_LSB];

   logic [GAIN_BITS-1:0] gain_l, gain_r;
   logic                 smute_l, smute_r;

   // Zero-cross enable is a pin: two-flop synchronised separately
   // Kept ahead of the channels that read it
   logic zc_en_s1_q;
   logic zc_en_s2_q;
   always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         zc_en_s1_q <= 1'b0;
         zc_en_s2_q <= 1'b0;
      end else begin
         zc_en_s1_q <= ZERO_CROSS_ENABLE_IN;
         zc_en_s2_q <= zc_en_s1_q;
      end
   end

   // Per-channel deferred update, codes 1..255 map to half-dB taps
   sgsc_zc_chan #(.TIMEOUT_CYC(ZC_TIMEOUT)) u_left (
      .clk_in        (SYS_CLK_IN),
      .arst_n_in     (ARST_N_IN),
      .clear_in      (clear_gains),
      .zc_enable_in  (zc_en_s2_q),
      .load_in       (load),
      .code_in       (code_l),
      .zero_cross_in (zcl_pos),
      .gain_out      (gain_l),
      .soft_mute_out (smute_l)
   );
   sgsc_zc_chan #(.TIMEOUT_CYC(ZC_TIMEOUT)) u_right (
      .clk_in        (SYS_CLK_IN),
      .arst_n_in     (ARST_N_IN),
      .clear_in      (clear_gains),
      .zc_enable_in  (zc_en_s2_q),
      .load_in       (load),
      .code_in       (code_r),
      .zero_cross_in (zcr_pos),
      .gain_out      (gain_r),
      .soft_mute_out (smute_r)
   );

   // Registered gain outputs
   // Soft mute is registered beside its code so the two never disagree
   always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         GAIN_LEFT_OUT       <= GAIN_RESET;
         GAIN_RIGHT_OUT      <= GAIN_RESET;
         SOFT_MUTE_LEFT_OUT  <= 1'b1;
         SOFT_MUTE_RIGHT_OUT <= 1'b1;
         READY_OUT           <= 1'b0;
      end else begin
         GAIN_LEFT_OUT       <= gain_l;
         GAIN_RIGHT_OUT      <= gain_r;
         SOFT_MUTE_LEFT_OUT  <= smute_l;
         SOFT_MUTE_RIGHT_OUT <= smute_r;
         READY_OUT           <= running;
      end
   end

   // Hardware mute: entry waits for any crossing or 16 ms, ignoring enable
   // Release is not click-guarded; a crossing on either channel ends the wait
   logic                mute_wait_q;
   logic [TMR_BITS-1:0] mute_tmr_q;
   always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         HW_MUTE_OUT <= 1'b1;
         mute_wait_q <= 1'b0;
         mute_tmr_q  <= '0;
      end else if (!running) begin
         HW_MUTE_OUT <= 1'b1;
         mute_wait_q <= 1'b0;
         mute_tmr_q  <= '0;
      end else if (mute_n) begin
         HW_MUTE_OUT <= 1'b0;                           // Release is immediate
         mute_wait_q <= 1'b0;
         mute_tmr_q  <= '0;
      end else if (!HW_MUTE_OUT && !mute_wait_q) begin
         mute_wait_q <= 1'b1;
         mute_tmr_q  <= '0;
      end else if (mute_wait_q) begin
         if (any_zc || mute_tmr_q >= ZC_TIMEOUT - 1) begin
            HW_MUTE_OUT <= 1'b1;
            mute_wait_q <= 1'b0;
         end else begin
            mute_tmr_q <= mute_tmr_q + 1'b1;
         end
      end
   end
endmodule // sgsc_core

// >>> src/sgsc_pkg.sv
// Purpose: Shared constants for the stereo gain serial control core
// Assumes: 250 MHz system clock
// Notes:   Times are held in their own units; cycle counts derive from them
package sgsc_pkg;
   localparam int unsigned CLK_HZ          = 250_000_000;
   localparam int unsigned WORD_BITS       = 16;
   localparam int unsigned GAIN_BITS       = 8;
   localparam int unsigned RIGHT_MSB       = 15;   // Right byte arrives first
   localparam int unsigned RIGHT_LSB       = 8;
   localparam int unsigned LEFT_MSB        = 7;
   localparam int unsigned LEFT_LSB        = 0;
   localparam logic [7:0]  GAIN_RESET      = 8'h00; // Software mute code
   localparam logic [7:0]  GAIN_MUTE_CODE  = 8'h00;
   localparam logic [15:0] SHIFT_RESET     = 16'h0000;
   localparam int unsigned ZC_TIMEOUT_MS   = 16;
   localparam int unsigned POR_TIME_MS     = 100;
   localparam int unsigned CAL_TIME_US     = 100;
   // Longest waits round down, least waits round up
   localparam longint unsigned ZC_TIMEOUT_CYC =
      (longint'(ZC_TIMEOUT_MS) * CLK_HZ) / 1000;
   localparam longint unsigned POR_CYC =
      (longint'(POR_TIME_MS) * CLK_HZ + 999) / 1000;
   localparam longint unsigned CAL_CYC =
      (longint'(CAL_TIME_US) * CLK_HZ + 999_999) / 1_000_000;
   localparam int unsigned TMR_BITS        = 32;

   // Power-up sequencer, Gray coded along the usual path
   typedef enum logic [1:0] {
      SGSC_PWR_RESET = 2'b00,
      SGSC_PWR_CAL   = 2'b01,
      SGSC_PWR_RUN   = 2'b11
   } sgsc_pwr_t;
endpackage

// >>> src/sgsc_zc_chan.sv
// Purpose: One channel of deferred gain update with zero-cross and timeout
// Assumes: Crossing strobe is synchronous to the system clock
// Notes:   Timeout counted on the system timebase, not the shift clock
`timescale 1ns/1ps
module sgsc_zc_chan
   import sgsc_pkg::*;
#(
   parameter logic [TMR_BITS-1:0] TIMEOUT_CYC = TMR_BITS'(ZC_TIMEOUT_CYC)
) (
   // Clock and reset
   input  wire logic                 clk_in,
   input  wire logic                 arst_n_in,
   input  wire logic                 clear_in,
   // Control
   input  wire logic                 zc_enable_in,
   input  wire logic                 load_in,
   input  wire logic [GAIN_BITS-1:0] code_in,
   input  wire logic                 zero_cross_in,
   // Result
   output logic      [GAIN_BITS-1:0] gain_out,
   output logic                      soft_mute_out
);
   logic [GAIN_BITS-1:0] pend_q;
   logic                 wait_q;
   logic [TMR_BITS-1:0]  tmr_q;
   logic                 apply;

   assign apply = wait_q && (zero_cross_in || tmr_q >= TIMEOUT_CYC - 1);

   // Pending code and its wait; only a changed code arms the wait
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         pend_q <= GAIN_RESET;
         wait_q <= 1'b0;
         tmr_q  <= '0;
      end else if (clear_in) begin
         pend_q <= GAIN_RESET;
         wait_q <= 1'b0;
         tmr_q  <= '0;
      end else if (load_in && code_in != gain_out) begin
         pend_q <= code_in;
         wait_q <= zc_enable_in;
         tmr_q  <= '0;
      end else if (apply) begin
         wait_q <= 1'b0;
         tmr_q  <= '0;
      end else if (wait_q) begin
         tmr_q  <= tmr_q + 1'b1;
      end
   end

   // Applied gain: immediate when zero-cross is off, else on cross or timeout
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         gain_out <= GAIN_RESET;
      end else if (clear_in) begin
         gain_out <= GAIN_RESET;
      end else if (load_in && code_in != gain_out && !zc_enable_in) begin
         gain_out <= code_in;
      end else if (apply) begin
         gain_out <= pend_q;
      end
   end

   // Code zero means software mute; taken straight from the code so it never lags it
   assign soft_mute_out = (gain_out == GAIN_MUTE_CODE);
endmodule // sgsc_zc_chan

// >>> testbench/sgsc_core_monitor.sv
// Purpose: Port checker for the stereo gain serial control core
// Assumes: Pins are asynchronous and seen after a short sync delay
// Notes:   Bound onto every core instance at the foot of this file
`timescale 1ns/1ps
module sgsc_core_monitor
   import sgsc_pkg::*;
#(
   parameter logic [TMR_BITS-1:0] ZC_TIMEOUT = TMR_BITS'(ZC_TIMEOUT_CYC)
) (
   // Clock, reset and pins
   input  wire logic       SYS_CLK_IN,
   input  wire logic       ARST_N_IN,
   input  wire logic       SEL_N_IN,
   input  wire logic       SHIFT_CLK_IN,
   input  wire logic       HW_MUTE_N_IN,
   input  wire logic       BROWN_OUT_IN,
   // Outputs watched
   input  wire logic       SERIAL_OUT_OUT,
   input  wire logic       SERIAL_OUT_OE_N_OUT,
   input  wire logic [7:0] GAIN_LEFT_OUT,
   input  wire logic [7:0] GAIN_RIGHT_OUT,
   input  wire logic       SOFT_MUTE_LEFT_OUT,
   input  wire logic       SOFT_MUTE_RIGHT_OUT,
   input  wire logic       HW_MUTE_OUT,
   input  wire logic       CAL_START_OUT,
   input  wire logic       READY_OUT
);
   // Sync delay and output register added to the timeout
   localparam int ZC_MAX = int'(ZC_TIMEOUT) + 8;
   default clocking @(posedge SYS_CLK_IN); endclocking
   default disable iff (!ARST_N_IN);

   a_oe_release: assert property (SEL_N_IN [*5] |-> SERIAL_OUT_OE_N_OUT)
      else $error("serial out driven while deselected");
   a_smute_left: assert property (SOFT_MUTE_LEFT_OUT == (GAIN_LEFT_OUT == 8'h00))
      else $error("left soft mute disagrees with code");
   a_smute_right: assert property (SOFT_MUTE_RIGHT_OUT == (GAIN_RIGHT_OUT == 8'h00))
      else $error("right soft mute disagrees with code");
   a_power_mute: assert property (!READY_OUT |-> HW_MUTE_OUT)
      else $error("unmuted before power-up done");
   a_power_zero: assert property (!READY_OUT |-> GAIN_LEFT_OUT == 8'h00 && GAIN_RIGHT_OUT == 8'h00)
      else $error("gain not zero before ready");
   a_cal_first: assert property ($rose(READY_OUT) |-> $past(CAL_START_OUT))
      else $error("ready without calibration");
   a_brown_mute: assert property (BROWN_OUT_IN [*5] |-> HW_MUTE_OUT && !READY_OUT)
      else $error("brown-out did not mute");
   a_mute_bound: assert property ($fell(HW_MUTE_N_IN) && READY_OUT |-> ##[1:ZC_MAX] HW_MUTE_OUT)
      else $error("hardware mute late");
   a_mute_cal: assert property ($fell(HW_MUTE_N_IN) && READY_OUT |-> ##[1:6] CAL_START_OUT)
      else $error("mute did not start calibration");
   // Output may only move shortly after a falling shift edge
   a_out_fall: assert property ($changed(SERIAL_OUT_OUT) && !SERIAL_OUT_OE_N_OUT &&
      !$past(SERIAL_OUT_OE_N_OUT) |-> !$past(SHIFT_CLK_IN, 2))
      else $error("serial out moved off falling edge");

   c_frame: cover property (!SERIAL_OUT_OE_N_OUT ##1 SERIAL_OUT_OE_N_OUT);
   c_mute: cover property ($rose(HW_MUTE_OUT) && READY_OUT);
   c_brown: cover property (BROWN_OUT_IN && HW_MUTE_OUT);
endmodule // sgsc_core_monitor

bind sgsc_core sgsc_core_monitor #(.ZC_TIMEOUT(ZC_TIMEOUT)) u_mon (
   .SYS_CLK_IN(SYS_CLK_IN), .ARST_N_IN(ARST_N_IN), .SEL_N_IN(SEL_N_IN),
   .SHIFT_CLK_IN(SHIFT_CLK_IN), .HW_MUTE_N_IN(HW_MUTE_N_IN), .BROWN_OUT_IN(BROWN_OUT_IN),
   .SERIAL_OUT_OUT(SERIAL_OUT_OUT), .SERIAL_OUT_OE_N_OUT(SERIAL_OUT_OE_N_OUT),
   .GAIN_LEFT_OUT(GAIN_LEFT_OUT), .GAIN_RIGHT_OUT(GAIN_RIGHT_OUT),
   .SOFT_MUTE_LEFT_OUT(SOFT_MUTE_LEFT_OUT), .SOFT_MUTE_RIGHT_OUT(SOFT_MUTE_RIGHT_OUT),
   .HW_MUTE_OUT(HW_MUTE_OUT), .CAL_START_OUT(CAL_START_OUT), .READY_OUT(READY_OUT));

// >>> testbench/sgsc_host_model.sv
// Purpose: Host side of the serial control port
// Assumes: Shift clock of 64 ns, 8 system clocks per phase
// Notes:   Shift clock stands still low between frames
`timescale 1ns/1ps
module sgsc_host_model (
   // System clock for pacing
   input  wire logic clk_in,
   // Chain output of the device
   input  wire logic so_in,
   input  wire logic so_oe_n_in,
   // Serial port drive
   output logic      sel_n_out,
   output logic      sck_out,
   output logic      sdata_out
);
   logic        so_last;  // Last driven level of the chain output
   logic        line;     // Released line drifts, so it reads inverted
   logic [31:0] cap;      // Bits returned on the chain output
   logic        oe_seen;  // Output driven at every sample of the frame but the first

   initial begin
      sel_n_out = 1'b1;
      sck_out   = 1'b0;
      sdata_out = 1'b0;
   end

   // Track the driven level so a release is visible
   always_ff @(posedge clk_in) begin
      if (!so_oe_n_in) so_last <= so_in;
   end
   assign line = so_oe_n_in ? ~so_last : so_in;

   // Shift n bits MSB first; sel high keeps select down for all of them
   task automatic frame(input logic [31:0] d, input int n, input bit sel);
      oe_seen   = 1'b1;
      sel_n_out = !sel;
      repeat (8) @(negedge clk_in);
      for (int i = n - 1; i >= 0; i--) begin
         sdata_out = d[i];
         repeat (8) @(negedge clk_in);
         cap = {cap[30:0], line};
         oe_seen &= (i == n - 1) | !so_oe_n_in;
         sck_out = 1'b1;
         repeat (8) @(negedge clk_in);
         sck_out = 1'b0;
      end
      // A downstream device samples only at rising edges: no sample after the last
      repeat (8) @(negedge clk_in);
      sel_n_out = 1'b1;
      repeat (8) @(negedge clk_in);
   endtask
endmodule // sgsc_host_model

// >>> testbench/sgsc_core_bench.sv
// Purpose: Self-checking bench for the stereo gain serial control core
// Assumes: Timeouts shortened to 50, 50 and 20 cycles
// Notes:   Inputs change on the falling system clock edge
`timescale 1ns/1ps
module sgsc_core_bench;
   import sgsc_pkg::*;
   logic       clk, arst_n, zc_en, mute_n, brown, zc_l, zc_r, cal_done, cal_seen;
   logic [7:0] gl, gr;
   logic       sm_l, sm_r, hw_mute, cal_start, ready, so, so_oe_n;
   wire logic  sel_n, sck, sdata;
   int         err_total, total_checks;

   // 250 MHz clock
   always #2 clk = ~clk;
   // Remember any calibration request
   always @(posedge clk) if (cal_start === 1'b1) cal_seen <= 1'b1;

   sgsc_core #(.ZC_TIMEOUT(32'h32), .POR_TIME(32'h32), .CAL_TIME(32'h14)) uut (
      .SYS_CLK_IN(clk), .ARST_N_IN(arst_n), .SEL_N_IN(sel_n), .SHIFT_CLK_IN(sck),
      .SERIAL_IN_IN(sdata), .SERIAL_OUT_OUT(so), .SERIAL_OUT_OE_N_OUT(so_oe_n),
      .ZERO_CROSS_ENABLE_IN(zc_en), .HW_MUTE_N_IN(mute_n), .BROWN_OUT_IN(brown),
      .ZC_LEFT_IN(zc_l), .ZC_RIGHT_IN(zc_r), .CAL_DONE_IN(cal_done),
      .GAIN_LEFT_OUT(gl), .GAIN_RIGHT_OUT(gr), .SOFT_MUTE_LEFT_OUT(sm_l),
      .SOFT_MUTE_RIGHT_OUT(sm_r), .HW_MUTE_OUT(hw_mute), .CAL_START_OUT(cal_start),
      .READY_OUT(ready));
   sgsc_host_model host (.clk_in(clk), .so_in(so), .so_oe_n_in(so_oe_n),
      .sel_n_out(sel_n), .sck_out(sck), .sdata_out(sdata));

   task automatic fail(input string m);
      err_total++;
      $display("CHECK FAILED t=%0t %s", $time, m);
   endtask
   task automatic chk1(input logic g, input logic e, input string m);
      total_checks++;
      if (g !== e) fail(m);
   endtask
   task automatic chk8(input logic [7:0] g, input logic [7:0] e, input string m);
      total_checks++;
      if (g !== e) fail(m);
   endtask
   task automatic chk16(input logic [15:0] g, input logic [15:0] e, input string m);
      total_checks++;
      if (g !== e) fail(m);
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic wait_ready();
      for (int i = 0; i < 300 && ready !== 1'b1; i++) @(negedge clk);
   endtask
   task automatic print_verdict();
      $display("Checks %0d, errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // Power-up hold, calibration, then both gains at zero
   task automatic t_power_up();
      chk1(hw_mute, 1'b1, "muted in hold");
      wait_ready();
      chk1(ready, 1'b1, "ready");
      chk1(cal_seen, 1'b1, "calibrated");
      chk8(gl, 8'h00, "left zero");
      chk8(gr, 8'h00, "right zero");
      chk1(sm_l, 1'b1, "left soft mute");
      chk1(so_oe_n, 1'b1, "idle release");
   endtask
   // Immediate loads, byte order and chain output
   task automatic t_direct();
      host.frame(32'hff01, 16, 1'b1);
      tick(6);
      chk8(gr, 8'hff, "right byte first");
      chk8(gl, 8'h01, "left byte msb first");
      chk1(sm_r, 1'b0, "right live");
      chk16(host.cap[15:0], 16'h0000, "old word out");
      host.frame(32'h00ff, 16, 1'b1);
      tick(6);
      chk8(gr, 8'h00, "right code zero");
      chk1(sm_r, 1'b1, "right soft mute");
      chk16(host.cap[15:0], 16'hff01, "chain word");
      chk1(host.oe_seen, 1'b1, "driven in frame");
   endtask
   // Two words in one frame: only the last lands, the first passes on
   task automatic t_chain();
      fork
         host.frame(32'h1234_5678, 32, 1'b1);
         begin
            tick(300);
            chk8(gl, 8'hff, "held while shifting");
         end
      join
      tick(6);
      chk8(gr, 8'h56, "last right");
      chk8(gl, 8'h78, "last left");
      chk16(host.cap[15:0], 16'h1234, "first word passed");
      chk16(host.cap[31:16], 16'h00ff, "old word passed");
   endtask
   // Shift clocks with select high are ignored
   task automatic t_refused();
      host.frame(32'haa55, 16, 1'b0);
      tick(6);
      chk8(gr, 8'h56, "right kept");
      chk8(gl, 8'h78, "left kept");
      chk1(so_oe_n, 1'b1, "still released");
   endtask
   // Deferred loads: right on its crossing, left by timeout
   task automatic t_zero_cross();
      zc_en = 1'b1;
      host.frame(32'h9a9b, 16, 1'b1);
      tick(20);
      chk8(gr, 8'h56, "right deferred");
      chk8(gl, 8'h78, "left deferred");
      zc_r = 1'b1;
      tick(8);
      zc_r = 1'b0;
      chk8(gr, 8'h9a, "right on crossing");
      chk8(gl, 8'h78, "left waits own");
      tick(40);
      chk8(gl, 8'h9b, "left on timeout");
      zc_en = 1'b0;
   endtask
   // Hardware mute by timeout, then by crossing with enable low
   task automatic t_hw_mute();
      cal_seen = 1'b0;
      mute_n = 1'b0;
      tick(20);
      chk1(hw_mute, 1'b0, "waits for crossing");
      chk1(cal_seen, 1'b1, "mute calibrates");
      tick(45);
      chk1(hw_mute, 1'b1, "muted on timeout");
      mute_n = 1'b1;
      tick(8);
      chk1(hw_mute, 1'b0, "unmuted");
      mute_n = 1'b0;
      tick(10);
      zc_l = 1'b1;
      tick(6);
      zc_l = 1'b0;
      chk1(hw_mute, 1'b1, "muted on crossing");
      mute_n = 1'b1;
      tick(8);
   endtask
   // Brown-out mutes and reruns power-up
   task automatic t_brown();
      brown = 1'b1;
      tick(8);
      chk1(hw_mute, 1'b1, "brown-out mute");
      chk1(ready, 1'b0, "not ready");
      brown = 1'b0;
      cal_done = 1'b1;
      wait_ready();
      chk1(ready, 1'b1, "rerun done");
      chk8(gl, 8'h00, "left cleared");
      chk8(gr, 8'h00, "right cleared");
      cal_done = 1'b0;
   endtask

   initial begin
      {clk, arst_n, zc_en, brown, zc_l, zc_r, cal_done, cal_seen} = 8'h00;
      mute_n = 1'b1;
      tick(12);
      arst_n = 1'b1;
      t_power_up();
      t_direct();
      t_chain();
      t_refused();
      t_zero_cross();
      t_hw_mute();
      t_brown();
      print_verdict();
   end
   // Watchdog well beyond the few thousand cycles the tests need
   initial begin
      repeat (20000) @(posedge clk);
      fail("watchdog");
      print_verdict();
   end
endmodule // sgsc_core_bench
